// [hdl/mrs_pkg.sv]
// Purpose: Constants and types for the low mode register set block.
// Assumes: One system clock, register access by mode register commands.
// Notes: Field positions, result codes and configuration reset values live here; timing code tables and the timing reset sit in mrs_regs.
package mrs_pkg;
	localparam logic [7:0] MA_DEV_INFO = 8'h00;
	localparam logic [7:0] MA_FEAT_ONE = 8'h01;
	localparam logic [7:0] MA_FEAT_TWO = 8'h02;
	localparam logic [7:0] MA_IO_CFG = 8'h03;
	localparam logic [7:0] MA_CAL = 8'h0a;
	// Field layout of the information register.
	localparam int AUTO_INIT_BIT = 0;
	localparam int SELFTEST_LSB = 3;
	localparam int ALT_WL_BIT = 6;
	localparam int LOW_LAT_BIT = 7;
	// Self-test result codes.
	localparam logic [1:0] ST_NOT_RUN = 2'h0;
	localparam logic [1:0] ST_SUPPLY = 2'h1;
	localparam logic [1:0] ST_GROUND = 2'h2;
	localparam logic [1:0] ST_OK = 2'h3;
	// Defaults and accepted codes.
	localparam logic [2:0] BL8_CODE = 3'h3;
	localparam logic [2:0] WR_DEF_CODE = 3'h0;
	localparam logic [3:0] RLWL_DEF_CODE = 4'h8;
	localparam logic EXT_WR_DEF = 1'b1;
	localparam logic WL_SET_A = 1'b0;
	localparam logic [3:0] DS_DEF_CODE = 4'h2;
	localparam logic [7:0] CAL_INIT_CODE = 8'hff;
	// Cycles an initialization calibration takes before its result is posted.
	localparam int CAL_TIME_NS = 1000;
	localparam int CLK_PERIOD_NS = 100;
	localparam int CAL_CYCLES = (CAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [7:0] CAL_CNT_INIT = 8'(CAL_CYCLES);

	typedef struct packed {
		logic [2:0] burst_length;
		logic [2:0] wr_code;
		logic [3:0] read_write_latency_select;
		logic extended_write_recovery_enable;
		logic write_latency_set_select;
		logic write_leveling;
		logic [3:0] drive_strength;
	} mrs_cfg_s;

	typedef struct packed {
		logic [4:0] write_recovery_cycles;
		logic [3:0] read_latency;
		logic [3:0] write_latency;
	} mrs_timing_s;
endpackage

// [hdl/mrs_regs.sv]
// Purpose: Low mode register set: information, two feature registers, I/O configuration.
// Assumes: Command decode upstream presents one-cycle write and read strobes.
// Notes: Read data is registered; one cycle after the read strobe it is valid.
`timescale 1ns/1ps

module mrs_regs (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic mrw_valid,
	input wire logic mrr_valid,
	input wire logic [7:0] mode_reg_address,
	input wire logic [7:0] mode_reg_operand,
	input wire logic init_busy,
	input wire logic cal_pin_on_supply,
	input wire logic cal_pin_on_ground,
	input wire logic [2:0] column_start,
	input wire logic burst_step,
	output logic [7:0] rd_data,
	output logic rd_valid,
	output logic strobe_toggle,
	output mrs_pkg::mrs_cfg_s cfg,
	output mrs_pkg::mrs_timing_s timing,
	output logic factory_trim,
	output logic cal_busy,
	output logic [2:0] burst_col
);
	import mrs_pkg::*;

	// ****************************************
	// Pin synchronisers
	// ****************************************
	logic [2:0] sync1_ff;
	logic [2:0] sync2_ff;
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			sync1_ff <= 3'h0;
			sync2_ff <= 3'h0;
		end else begin
			sync1_ff <= {init_busy, cal_pin_on_supply, cal_pin_on_ground};
			sync2_ff <= sync1_ff;
		end
	end
	// Held at zero in reset, the auto-init flag reads complete for two cycles after release.
	// A controller must let the synchroniser fill before it trusts that bit.
	wire init_busy_s = sync2_ff[2];
	wire pin_supply_s = sync2_ff[1];
	wire pin_ground_s = sync2_ff[0];

	// ****************************************
	// Address decode and code checks
	// ****************************************
	wire sel_info = (mode_reg_address == MA_DEV_INFO);
	wire sel_one = (mode_reg_address == MA_FEAT_ONE);
	wire sel_two = (mode_reg_address == MA_FEAT_TWO);
	wire sel_io = (mode_reg_address == MA_IO_CFG);
	wire cal_init_cmd = mrw_valid && (mode_reg_address == MA_CAL) && (mode_reg_operand == CAL_INIT_CODE);
	wire [2:0] op_bl = mode_reg_operand[2:0];
	wire [2:0] op_wr = mode_reg_operand[7:5];
	wire [3:0] op_lat = mode_reg_operand[3:0];
	wire op_ext = mode_reg_operand[4];
	wire op_wlset = mode_reg_operand[6];
	wire op_lev = mode_reg_operand[7];

	mrs_cfg_s cfg_ff;
	mrs_cfg_s nxt_cfg;
	// Write-recovery code legality depends on the encoding in force at write time.
	wire wr_ok_norm = (op_wr == 3'h4) || (op_wr == 3'h6) || (op_wr == 3'h7);
	wire wr_ok_ext = (op_wr == 3'h0) || (op_wr == 3'h1) || (op_wr == 3'h2) ||
		(op_wr == 3'h4) || (op_wr == 3'h6);
	wire wr_ok = cfg_ff.extended_write_recovery_enable ? wr_ok_ext : wr_ok_norm;
	wire bl_ok = (op_bl == BL8_CODE);
	wire lat_ok = (op_lat == 4'h4) || (op_lat == 4'h6) || (op_lat == 4'h7) ||
		(op_lat == 4'h8) || (op_lat == 4'h9) || (op_lat == 4'ha) || (op_lat == 4'hc);
	wire ds_ok = (op_lat == 4'h1) || (op_lat == 4'h2) || (op_lat == 4'h3) || (op_lat == 4'h4) ||
		(op_lat == 4'h6) || (op_lat == 4'h9) || (op_lat == 4'ha) || (op_lat == 4'hb);

	// ****************************************
	// Writable configuration
	// ****************************************
	always_comb begin
		nxt_cfg = cfg_ff;
		if (mrw_valid && sel_one) begin
			if (bl_ok) nxt_cfg.burst_length = op_bl;
			if (wr_ok) nxt_cfg.wr_code = op_wr;
		end
		if (mrw_valid && sel_two) begin
			if (lat_ok) nxt_cfg.read_write_latency_select = op_lat;
			nxt_cfg.extended_write_recovery_enable = op_ext;
			if (op_wlset == WL_SET_A) nxt_cfg.write_latency_set_select = op_wlset;
			nxt_cfg.write_leveling = op_lev;
		end
		if (mrw_valid && sel_io && ds_ok) nxt_cfg.drive_strength = op_lat;
	end
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			cfg_ff <= '{BL8_CODE, WR_DEF_CODE, RLWL_DEF_CODE, EXT_WR_DEF, WL_SET_A, 1'b0,
				DS_DEF_CODE};
		end else begin
			cfg_ff <= nxt_cfg;
		end
	end
	assign cfg = cfg_ff;

	// ****************************************
	// Derived timing
	// ****************************************
	logic [4:0] wr_cycles;
	logic [3:0] rl_val;
	logic [3:0] wl_val;
	// A code that the encoding now in force calls reserved decodes to a fixed fallback count,
	// so the precharge timer never loads an undefined value.
	always_comb begin
		wr_cycles = 5'd10;
		if (cfg_ff.extended_write_recovery_enable) begin
			unique case (cfg_ff.wr_code)
				3'h0: wr_cycles = 5'd10;
				3'h1: wr_cycles = 5'd11;
				3'h2: wr_cycles = 5'd12;
				3'h4: wr_cycles = 5'd14;
				3'h6: wr_cycles = 5'd16;
				default: wr_cycles = 5'd10;
			endcase
		end else begin
			unique case (cfg_ff.wr_code)
				3'h4: wr_cycles = 5'd6;
				3'h6: wr_cycles = 5'd8;
				3'h7: wr_cycles = 5'd9;
				default: wr_cycles = 5'd9;
			endcase
		end
		unique case (cfg_ff.read_write_latency_select)
			4'h4: begin rl_val = 4'd6; wl_val = 4'd3; end
			4'h6: begin rl_val = 4'd8; wl_val = 4'd4; end
			4'h7: begin rl_val = 4'd9; wl_val = 4'd5; end
			4'h9: begin rl_val = 4'd11; wl_val = 4'd6; end
			4'ha: begin rl_val = 4'd12; wl_val = 4'd6; end
			4'hc: begin rl_val = 4'd14; wl_val = 4'd8; end
			default: begin rl_val = 4'd10; wl_val = 4'd6; end
		endcase
	end
	// The write-recovery count is what the auto-precharge timer loads.
	mrs_timing_s timing_ff;
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) timing_ff <= '{5'd10, 4'd10, 4'd6};
		else timing_ff <= '{wr_cycles, rl_val, wl_val};
	end
	assign timing = timing_ff;

	// ****************************************
	// Calibration self-test
	// ****************************************
	logic [1:0] selftest_ff;
	logic [7:0] cal_cnt_ff;
	logic cal_busy_ff;
	logic trim_ff;
	wire fault = (selftest_ff == ST_SUPPLY) || (selftest_ff == ST_GROUND);
	wire cal_accept = cal_init_cmd && !fault && !cal_busy_ff;
	wire cal_done = cal_busy_ff && (cal_cnt_ff == 8'h01);
	wire [1:0] st_result = pin_supply_s ? ST_SUPPLY : (pin_ground_s ? ST_GROUND : ST_OK);
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			selftest_ff <= ST_NOT_RUN;
			cal_cnt_ff <= 8'h00;
			cal_busy_ff <= 1'b0;
			trim_ff <= 1'b0;
		end else begin
			if (cal_accept) begin
				cal_busy_ff <= 1'b1;
				cal_cnt_ff <= CAL_CNT_INIT;
			end else if (cal_done) begin
				cal_busy_ff <= 1'b0;
				cal_cnt_ff <= 8'h00;
				selftest_ff <= st_result;
				trim_ff <= (st_result != ST_OK);
			end else if (cal_busy_ff) begin
				cal_cnt_ff <= cal_cnt_ff - 8'h01;
			end
		end
	end
	assign factory_trim = trim_ff;
	assign cal_busy = cal_busy_ff;

	// ****************************************
	// Read path
	// ****************************************
	logic [7:0] info_word;
	always_comb begin
		info_word = 8'h00;
		info_word[AUTO_INIT_BIT] = init_busy_s;
		info_word[SELFTEST_LSB +: 2] = selftest_ff;
		info_word[ALT_WL_BIT] = 1'b0;
		info_word[LOW_LAT_BIT] = 1'b0;
	end
	logic [7:0] rd_ff;
	logic rdv_ff;
	logic tog_ff;
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			rd_ff <= 8'h00;
			rdv_ff <= 1'b0;
			tog_ff <= 1'b0;
		end else begin
			rdv_ff <= mrr_valid;
			tog_ff <= mrr_valid;
			// Unreadable registers give zero here, which is one legal undefined value.
			if (mrr_valid) rd_ff <= sel_info ? info_word : 8'h00;
		end
	end
	assign rd_data = rd_ff;
	assign rd_valid = rdv_ff;
	assign strobe_toggle = tog_ff;

	// ****************************************
	// Burst address sequence
	// ****************************************
	logic [2:0] col_ff;
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) col_ff <= 3'h0;
		else if (!burst_step) col_ff <= {column_start[2:1], 1'b0};
		else col_ff <= col_ff + 3'h1;
	end
	assign burst_col = col_ff;

	// ****************************************
	// Checks
	// ****************************************
	property p_info_zero;
		@(posedge clk_sys) disable iff (!nrst)
		mrr_valid && sel_info |=> rd_valid && rd_data[7:5] == 3'h0 && rd_data[2:1] == 2'h0;
	endproperty
	a_info_zero: assert property (p_info_zero) else $error("info reserved bits set");
	property p_selftest_hold;
		@(posedge clk_sys) disable iff (!nrst)
		!cal_done |=> $stable(selftest_ff);
	endproperty
	a_selftest_hold: assert property (p_selftest_hold) else $error("selftest moved");
	property p_fault_ignore;
		@(posedge clk_sys) disable iff (!nrst)
		fault && !cal_busy_ff |=> !cal_busy_ff;
	endproperty
	a_fault_ignore: assert property (p_fault_ignore) else $error("cal ran on fault");
	property p_bl_fixed;
		@(posedge clk_sys) disable iff (!nrst) cfg.burst_length == BL8_CODE;
	endproperty
	a_bl_fixed: assert property (p_bl_fixed) else $error("burst length changed");
	property p_wlset;
		@(posedge clk_sys) disable iff (!nrst) cfg.write_latency_set_select == WL_SET_A;
	endproperty
	a_wlset: assert property (p_wlset) else $error("set B selected");
	property p_lev;
		@(posedge clk_sys) disable iff (!nrst)
		mrw_valid && sel_two |=> cfg.write_leveling == $past(op_lev);
	endproperty
	a_lev: assert property (p_lev) else $error("leveling not stored");
	property p_wrap;
		@(posedge clk_sys) disable iff (!nrst)
		!burst_step ##1 burst_step [*8] |=> burst_col == $past(burst_col, 8);
	endproperty
	a_wrap: assert property (p_wrap) else $error("burst did not wrap");
	property p_col0;
		@(posedge clk_sys) disable iff (!nrst) !burst_step |=> burst_col[0] == 1'b0;
	endproperty
	a_col0: assert property (p_col0) else $error("column bit zero set");
	property p_strobe;
		@(posedge clk_sys) disable iff (!nrst) mrr_valid |=> strobe_toggle;
	endproperty
	a_strobe: assert property (p_strobe) else $error("no strobe on read");
	// ****************************************
	// Checks on register writes and reads, calibration and the burst start column
	// ****************************************
	// The wait matches the counter load, so a stretched or cut calibration shows here.
	localparam int CAL_WAIT = CAL_CYCLES;
	property p_cal_len;
		@(posedge clk_sys) disable iff (!nrst)
		cal_accept |-> ##CAL_WAIT cal_done;
	endproperty
	a_cal_len: assert property (p_cal_len) else $error("calibration length wrong");
	property p_pin_supply;
		@(posedge clk_sys) disable iff (!nrst)
		cal_done && pin_supply_s |=> selftest_ff == ST_SUPPLY && factory_trim;
	endproperty
	a_pin_supply: assert property (p_pin_supply) else $error("supply pin missed");
	property p_rd_unread;
		@(posedge clk_sys) disable iff (!nrst)
		mrr_valid && !sel_info |=> rd_valid && rd_data == 8'h00;
	endproperty
	a_rd_unread: assert property (p_rd_unread) else $error("unreadable gave data");
	property p_lat_pair;
		@(posedge clk_sys) disable iff (!nrst)
		mrw_valid && sel_two && op_lat == 4'hc |=> ##1 timing.read_latency == 4'd14 &&
			timing.write_latency == 4'd8;
	endproperty
	a_lat_pair: assert property (p_lat_pair) else $error("latency pair wrong");
	property p_lat_keep;
		@(posedge clk_sys) disable iff (!nrst)
		mrw_valid && sel_two && !lat_ok |=> $stable(cfg.read_write_latency_select);
	endproperty
	a_lat_keep: assert property (p_lat_keep) else $error("reserved latency stored");
	property p_ds_keep;
		@(posedge clk_sys) disable iff (!nrst)
		mrw_valid && sel_io && !ds_ok |=> $stable(cfg.drive_strength);
	endproperty
	a_ds_keep: assert property (p_ds_keep) else $error("reserved drive stored");
	property p_ro_write;
		@(posedge clk_sys) disable iff (!nrst)
		mrw_valid && sel_info |=> $stable(cfg);
	endproperty
	a_ro_write: assert property (p_ro_write) else $error("read-only write acted");
	// A deasserted step must reload the start column with its lowest bit cleared.
	property p_col_load;
		@(posedge clk_sys) disable iff (!nrst)
		!burst_step |=> burst_col == {$past(column_start[2:1]), 1'b0};
	endproperty
	a_col_load: assert property (p_col_load) else $error("start column wrong");
	c_cal: cover property (@(posedge clk_sys) disable iff (!nrst) cal_done);
	c_read: cover property (@(posedge clk_sys) disable iff (!nrst) mrr_valid && sel_info);
	c_ext_off: cover property (@(posedge clk_sys) disable iff (!nrst)
		!cfg.extended_write_recovery_enable);
	c_fault: cover property (@(posedge clk_sys) disable iff (!nrst)
		cal_done && st_result != ST_OK);
	c_wrap: cover property (@(posedge clk_sys) disable iff (!nrst)
		burst_step && burst_col == 3'h7);
endmodule // mrs_regs

// [dv/mrs_ctrl_model.sv]
// Purpose: Controller side that issues mode register write and read commands.
// Assumes: Commands launch on the falling edge; one command per call.
// Notes: Released address and operand lines show the inverse of the last value, never a stale copy; both strobes drop to zero.
`timescale 1ns/1ps
module mrs_ctrl_model (
	input wire logic clk_sys,
	output logic mrw_valid,
	output logic mrr_valid,
	output logic [7:0] mode_reg_address,
	output logic [7:0] mode_reg_operand
);
	// ****************
	// Command driver
	// ****************
	initial begin
		mrw_valid = 1'b0;
		mrr_valid = 1'b0;
		mode_reg_address = 8'h55;
		mode_reg_operand = 8'haa;
	end

	// The strobe is held across one sampling edge; an idle cycle follows.
	task automatic issue(input logic wr, input logic [7:0] a, input logic [7:0] op);
		@(negedge clk_sys);
		mrw_valid = wr;
		mrr_valid = !wr;
		mode_reg_address = a;
		mode_reg_operand = op;
		@(negedge clk_sys);
		mrw_valid = 1'b0;
		mrr_valid = 1'b0;
		mode_reg_address = ~a;
		mode_reg_operand = ~op;
	endtask
endmodule // mrs_ctrl_model

// [dv/sdram_mode_register_set_low_test.sv]
// Purpose: Self-checking bench for the low mode register set.
// Assumes: Reads are scored from a queue by a watching process.
// Notes: Pin inputs pass a two-flop synchronizer, so waits follow each change.
`timescale 1ns/1ps
module sdram_mode_register_set_low_test;
	import mrs_pkg::*;
	logic clk_sys = 1'b0;
	logic nrst = 1'b0;
	logic init_busy = 1'b1;
	logic cal_pin_on_supply = 1'b0;
	logic cal_pin_on_ground = 1'b0;
	logic burst_step = 1'b0;
	logic [2:0] column_start = 3'h0;
	logic mrw_valid, mrr_valid, rd_valid, strobe_toggle, factory_trim, cal_busy;
	logic [7:0] mode_reg_address, mode_reg_operand, rd_data;
	logic [2:0] burst_col;
	logic [3:0] dse;
	mrs_cfg_s cfg;
	mrs_timing_s timing;
	logic [7:0] exp_q[$];
	logic [3:0] lc[8] = '{4'h4, 4'h6, 4'h7, 4'h8, 4'h9, 4'ha, 4'hc, 4'h1};
	logic [7:0] lrw[8] = '{8'h63, 8'h84, 8'h95, 8'ha6, 8'hb6, 8'hc6, 8'he8, 8'he8};
	logic [2:0] wc[10] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h6, 3'h3, 3'h4, 3'h6, 3'h7, 3'h1};
	logic [4:0] wn[10] = '{5'ha, 5'hb, 5'hc, 5'he, 5'h10, 5'h10, 5'h6, 5'h8, 5'h9, 5'h9};
	int fail_count = 0;
	int cmp_count = 0;
	int seed = 95091;
	int i;

	always #50 clk_sys = ~clk_sys;

	mrs_regs mrs_regs_inst (.clk_sys(clk_sys), .nrst(nrst), .mrw_valid(mrw_valid),
		.mrr_valid(mrr_valid), .mode_reg_address(mode_reg_address),
		.mode_reg_operand(mode_reg_operand), .init_busy(init_busy),
		.cal_pin_on_supply(cal_pin_on_supply), .cal_pin_on_ground(cal_pin_on_ground),
		.column_start(column_start), .burst_step(burst_step), .rd_data(rd_data),
		.rd_valid(rd_valid), .strobe_toggle(strobe_toggle), .cfg(cfg), .timing(timing),
		.factory_trim(factory_trim), .cal_busy(cal_busy), .burst_col(burst_col));
	mrs_ctrl_model mrs_ctrl_model_inst (.clk_sys(clk_sys), .mrw_valid(mrw_valid),
		.mrr_valid(mrr_valid), .mode_reg_address(mode_reg_address),
		.mode_reg_operand(mode_reg_operand));

	// ****************
	// Shared tasks
	// ****************
	task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic test_done();
		$display("Comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		mrs_ctrl_model_inst.issue(1'b0, a, 8'h00);
	endtask
	// Returns once cfg and the derived timing have both settled.
	task automatic wr(input logic [7:0] a, input logic [7:0] op);
		mrs_ctrl_model_inst.issue(1'b1, a, op);
		@(negedge clk_sys);
	endtask
	task automatic settle();
		repeat (4) @(negedge clk_sys);
	endtask
	task automatic calibrate(input logic busy, input logic [7:0] e, input logic trim);
		int n;
		wr(8'h0a, CAL_INIT_CODE);
		check("cal_busy", 24'(cal_busy), 24'(busy));
		for (n = 0; n < 40 && cal_busy !== 1'b0; n++) begin
			@(negedge clk_sys);
		end
		if (n == 40) begin
			fail_count++;
			test_done();
		end
		rd(MA_DEV_INFO, e);
		check("factory_trim", 24'(factory_trim), 24'(trim));
	endtask
	task automatic do_reset();
		nrst = 1'b0;
		repeat (20) @(negedge clk_sys);
		nrst = 1'b1;
		settle();
	endtask

	always @(negedge clk_sys) begin
		if (rd_valid === 1'b1) begin
			check("strobe_toggle", 24'(strobe_toggle), 24'h1);
			if (exp_q.size() == 0) begin
				check("rd_valid", 24'h1, 24'h0);
			end else begin
				check("rd_data", 24'(rd_data), 24'(exp_q.pop_front()));
			end
		end
	end

	// ****************
	// Main sequence
	// ****************
	initial begin
		do_reset();
		check("cfg", 24'(cfg), 24'({BL8_CODE, WR_DEF_CODE, RLWL_DEF_CODE, EXT_WR_DEF,
			WL_SET_A, 1'b0, DS_DEF_CODE}));
		check("timing", 24'(timing), 24'({5'ha, 4'ha, 4'h6}));
		rd(MA_DEV_INFO, 8'h01);
		init_busy = 1'b0;
		settle();
		wr(MA_DEV_INFO, 8'($random(seed)));
		for (i = 0; i < 5; i++) rd(8'(i), 8'h00);
		for (i = 0; i < 8; i++) begin
			wr(MA_FEAT_TWO, {4'h1, lc[i]});
			check("rw_lat", 24'({timing.read_latency, timing.write_latency}), 24'(lrw[i]));
			check("rw_code", 24'(cfg.read_write_latency_select), 24'(i == 7 ? 4'hc : lc[i]));
		end
		wr(MA_FEAT_TWO, 8'hdc);
		check("lev_set", 24'({cfg.write_leveling, cfg.write_latency_set_select}), 24'h2);
		for (i = 0; i < 10; i++) begin
			if (i == 6) wr(MA_FEAT_TWO, 8'h0c);
			wr(MA_FEAT_ONE, {wc[i], 2'h0, (i == 0 ? 3'h2 : BL8_CODE)});
			check("wr_cycles", 24'(timing.write_recovery_cycles), 24'(wn[i]));
			check("ext_bl", 24'({cfg.extended_write_recovery_enable, cfg.burst_length}),
				24'({i < 6, BL8_CODE}));
		end
		dse = DS_DEF_CODE;
		for (i = 0; i < 16; i++) begin
			wr(MA_IO_CFG, 8'(i));
			if (16'h0e5e >> i & 1) dse = 4'(i);
			check("drive", 24'(cfg.drive_strength), 24'(dse));
		end
		column_start = 3'($random(seed)) | 3'h1;
		@(negedge clk_sys);
		burst_step = 1'b1;
		for (i = 0; i < 9; i++) begin
			check("burst_col", 24'(burst_col), 24'(3'((column_start & 3'h6) + 3'(i))));
			@(negedge clk_sys);
		end
		burst_step = 1'b0;
		calibrate(1'b1, 8'h18, 1'b0);
		cal_pin_on_ground = 1'b1;
		settle();
		rd(MA_DEV_INFO, 8'h18);
		calibrate(1'b1, 8'h10, 1'b1);
		calibrate(1'b0, 8'h10, 1'b1);
		cal_pin_on_supply = 1'b1;
		do_reset();
		rd(MA_DEV_INFO, 8'h00);
		calibrate(1'b1, 8'h08, 1'b1);
		settle();
		check("reads_left", 24'(exp_q.size()), 24'h0);
		test_done();
	end
endmodule // sdram_mode_register_set_low_test
